// >>> pkg/sbl_pkg.sv
/*
  Constants, command and state types for the SDRAM bank state tracker.
  Assumes a 50 MHz system clock; timing figures are converted to cycles.
*/
package sbl_pkg;
  localparam int unsigned CLK_PERIOD_PS = 20000;
  localparam int unsigned BANKS = 4;
  localparam int unsigned BANK_W = 2;
  // Timing figures in ns, plain defaults; each is a least time
  localparam int unsigned PRECHARGE_WAIT_NS = 20;
  localparam int unsigned ACTIVATE_TO_ACCESS_NS = 20;
  localparam int unsigned REFRESH_CYCLE_NS = 70;
  localparam int unsigned MODE_LOAD_WAIT_NS = 40;
  localparam int unsigned SELF_REFRESH_EXIT_NS = 80;
  localparam int unsigned BURST_LEN = 4;
  localparam int unsigned CNT_W = 8;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int unsigned PRECHARGE_WAIT_CYC = ns_to_cyc(PRECHARGE_WAIT_NS);
  localparam int unsigned ACT_ACCESS_CYC = ns_to_cyc(ACTIVATE_TO_ACCESS_NS);
  localparam int unsigned REFRESH_CYC = ns_to_cyc(REFRESH_CYCLE_NS);
  localparam int unsigned MODE_LOAD_CYC = ns_to_cyc(MODE_LOAD_WAIT_NS);
  localparam int unsigned SELF_EXIT_CYC = ns_to_cyc(SELF_REFRESH_EXIT_NS);

  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACTIVATE = 4'h2,
    CMD_READ = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_PRECHARGE = 4'h5,
    CMD_BURST_STOP = 4'h6,
    CMD_REFRESH = 4'h7,
    CMD_MODE_LOAD = 4'h8
  } sbl_cmd_t;

  typedef enum logic [7:0] {
    BK_IDLE = 8'h01,
    BK_ACTIVATING = 8'h02,
    BK_ACTIVE = 8'h04,
    BK_READ = 8'h08,
    BK_WRITE = 8'h10,
    BK_READ_AP = 8'h20,
    BK_WRITE_AP = 8'h40,
    BK_PRECHARGING = 8'h80
  } sbl_bank_t;

  typedef enum logic [4:0] {
    DV_NORMAL = 5'h01,
    DV_REFRESH = 5'h02,
    DV_MODE_LOAD = 5'h04,
    DV_PRECH_ALL = 5'h08,
    DV_SELF_EXIT = 5'h10
  } sbl_dev_t;
endpackage : sbl_pkg

// >>> rtl/sbl_bank.sv
/*
  One bank's state record with its own timer.
  Assumes the top decodes commands and only steers this bank when legal.
*/
`timescale 1ns/1ps
module sbl_bank
  import sbl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic go_act,
  input wire logic go_read,
  input wire logic go_write,
  input wire logic go_prech,
  input wire logic auto_prech,
  input wire logic stop_burst,
  input wire logic force_idle,
  output sbl_bank_t state
);
  logic [CNT_W-1:0] timer;
  logic in_burst;
  logic [CNT_W-1:0] next_timer;

  assign in_burst = (state == BK_READ) || (state == BK_WRITE) ||
                    (state == BK_READ_AP) || (state == BK_WRITE_AP);

  always_comb begin
    next_timer = (timer != '0) ? timer - 1'b1 : timer;
    if (go_act) begin
      next_timer = CNT_W'(ACT_ACCESS_CYC - 1);
    end else if (go_read || go_write) begin
      next_timer = CNT_W'(BURST_LEN - 1);
    end else if (go_prech && state != BK_IDLE) begin
      next_timer = CNT_W'(PRECHARGE_WAIT_CYC - 1);
    end else if (in_burst && timer == '0 &&
                 (state == BK_READ_AP || state == BK_WRITE_AP)) begin
      next_timer = CNT_W'(PRECHARGE_WAIT_CYC - 1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer <= '0;
    end else if (ce) begin
      timer <= next_timer;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= BK_IDLE;
    end else if (ce) begin
      if (force_idle) begin
        state <= BK_IDLE;
      end else if (go_act) begin
        state <= BK_ACTIVATING;
      end else if (go_read) begin
        state <= auto_prech ? BK_READ_AP : BK_READ;
      end else if (go_write) begin
        state <= auto_prech ? BK_WRITE_AP : BK_WRITE;
      end else if (go_prech) begin
        if (state != BK_IDLE) begin
          state <= BK_PRECHARGING;
        end
      end else if (stop_burst && (state == BK_READ || state == BK_WRITE)) begin
        state <= BK_ACTIVE;
      end else begin
        unique case (state)
          BK_ACTIVATING: if (timer == '0) state <= BK_ACTIVE;
          BK_READ, BK_WRITE: if (timer == '0) state <= BK_ACTIVE;
          BK_READ_AP, BK_WRITE_AP: begin
            if (timer == '0) begin
              state <= BK_PRECHARGING;
            end
          end
          BK_PRECHARGING: if (timer == '0) state <= BK_IDLE;
          BK_IDLE, BK_ACTIVE: state <= state;
          default: state <= BK_IDLE;
        endcase
      end
    end
  end
endmodule : sbl_bank

// >>> rtl/sbl_legality.sv
/*
  Command decode, legality check and per-bank state tracking for a
  four-bank synchronous DRAM. Command pins are sampled on the rising edge
  and are synchronous to clk_sys.
*/
// Overview of operation
// - Tables act only with clock enable high on both edges, after exit wait.
// - Bank idle only after precharge and its wait time elapsed.
// - Row active once activate-to-access time elapsed, no burst running.
// - Read state lasts from read start until burst ends or is cut.
// - Write state lasts from write start until burst ends or is cut.
// - Activating starts at activate, ends after access time, then row active.
// - Access with auto precharge runs into precharge, then bank idles.
// - Mode load busies device for its wait; then all banks idle.
// - Refresh busies device for refresh interval; then all banks idle.
// - Precharge-all busies device for precharge wait; then all idle.
// - Burst stop ends the latest started burst, whichever bank, if it is a plain read or write.
// - Precharge to an idle bank leaves it unchanged.
// - Commands decode from the four strobe pins as tabulated.
// - Commands to other banks are accepted per their own state.
// - Precharge with address bit high hits all banks, else one bank.
// - Read or write with address bit high enables auto precharge.
`timescale 1ns/1ps
module sbl_legality
  import sbl_pkg::*;
#(
  parameter int unsigned NUM_BANKS = BANKS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic clock_enable_input,
  input wire logic self_refresh_exit,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [BANK_W-1:0] bank_select,
  input wire logic auto_precharge_address_bit,
  output logic cmd_accepted,
  output logic cmd_illegal,
  output logic all_idle,
  output sbl_dev_t device_state,
  output logic [NUM_BANKS*8-1:0] bank_states
);
  ////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic sbl_cmd_t decode(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    if (cs_n) return CMD_INHIBIT;
    unique case ({ras_n, cas_n, we_n})
      3'b111: return CMD_NOP;
      3'b011: return CMD_ACTIVATE;
      3'b101: return CMD_READ;
      3'b100: return CMD_WRITE;
      3'b010: return CMD_PRECHARGE;
      3'b110: return CMD_BURST_STOP;
      3'b001: return CMD_REFRESH;
      default: return CMD_MODE_LOAD;
    endcase
  endfunction : decode

  function automatic logic may_prech(input sbl_bank_t s);
    return (s == BK_IDLE) || (s == BK_ACTIVE) || (s == BK_READ) ||
           (s == BK_WRITE);
  endfunction : may_prech

  sbl_cmd_t cmd;
  logic cke_prev;
  logic tables_on;
  logic [CNT_W-1:0] dev_timer;
  logic [BANK_W-1:0] last_burst_bank;
  logic burst_valid;
  sbl_bank_t bstate [NUM_BANKS];
  logic [NUM_BANKS-1:0] go_act, go_read, go_write, go_prech, stop_burst;
  logic [NUM_BANKS-1:0] bank_idle, bank_ok_prech;
  logic dev_busy, prech_all, legal;
  sbl_bank_t sel;

  assign cmd = decode(chip_select_n, row_strobe_n, column_strobe_n,
                      write_strobe_n);
  assign tables_on = cke_prev && clock_enable_input &&
                     (device_state != DV_SELF_EXIT);
  assign dev_busy = (device_state != DV_NORMAL);
  assign all_idle = &bank_idle;
  assign sel = bstate[bank_select];
  assign prech_all = (cmd == CMD_PRECHARGE) && auto_precharge_address_bit;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cke_prev <= 1'b0;
    end else if (ce) begin
      cke_prev <= clock_enable_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Legality against the addressed bank; refresh, mode load and precharge-all check all banks, burst stop the last burst bank
  always_comb begin
    legal = 1'b1;
    if (cmd != CMD_INHIBIT && cmd != CMD_NOP) begin
      if (!tables_on || dev_busy) begin
        legal = 1'b0;
      end else begin
        unique case (cmd)
          CMD_ACTIVATE: legal = (sel == BK_IDLE);
          CMD_READ, CMD_WRITE: legal = (sel == BK_ACTIVE) ||
                                       (sel == BK_READ) || (sel == BK_WRITE);
          CMD_PRECHARGE: legal = prech_all ? (&bank_ok_prech)
                                           : may_prech(sel);
          // Only a plain read or write burst still running may be cut
          CMD_BURST_STOP: legal = burst_valid &&
                          (bstate[last_burst_bank] == BK_READ ||
                           bstate[last_burst_bank] == BK_WRITE);
          CMD_REFRESH, CMD_MODE_LOAD: legal = all_idle;
          default: legal = 1'b1;
        endcase
      end
    end
  end

  assign cmd_accepted = legal && cmd != CMD_INHIBIT && cmd != CMD_NOP;
  assign cmd_illegal = !legal;

  ////////////////////////////////////////////////////////////////////////
  // Device-wide state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      device_state <= DV_NORMAL;
      dev_timer <= '0;
    end else if (ce) begin
      unique case (device_state)
        DV_NORMAL: begin
          if (self_refresh_exit) begin
            device_state <= DV_SELF_EXIT;
            dev_timer <= CNT_W'(SELF_EXIT_CYC - 1);
          end else if (cmd_accepted && cmd == CMD_REFRESH) begin
            device_state <= DV_REFRESH;
            dev_timer <= CNT_W'(REFRESH_CYC - 1);
          end else if (cmd_accepted && cmd == CMD_MODE_LOAD) begin
            device_state <= DV_MODE_LOAD;
            dev_timer <= CNT_W'(MODE_LOAD_CYC - 1);
          end else if (cmd_accepted && prech_all) begin
            device_state <= DV_PRECH_ALL;
            dev_timer <= CNT_W'(PRECHARGE_WAIT_CYC - 1);
          end
        end
        DV_REFRESH, DV_MODE_LOAD, DV_PRECH_ALL, DV_SELF_EXIT: begin
          if (dev_timer == '0) begin
            device_state <= DV_NORMAL;
          end else begin
            dev_timer <= dev_timer - 1'b1;
          end
        end
        default: device_state <= DV_NORMAL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Most recent burst, for burst stop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_burst_bank <= '0;
      burst_valid <= 1'b0;
    end else if (ce) begin
      if (cmd_accepted && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
        last_burst_bank <= bank_select;
        burst_valid <= 1'b1;
      end else if (cmd_accepted && cmd == CMD_BURST_STOP) begin
        burst_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bank records
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      logic hit;
      assign hit = (bank_select == BANK_W'(g));
      assign go_act[g] = cmd_accepted && cmd == CMD_ACTIVATE && hit;
      assign go_read[g] = cmd_accepted && cmd == CMD_READ && hit;
      assign go_write[g] = cmd_accepted && cmd == CMD_WRITE && hit;
      // Precharge-all is tracked device-wide; banks are cleared at its end
      assign go_prech[g] = cmd_accepted && cmd == CMD_PRECHARGE &&
                           !auto_precharge_address_bit && hit;
      assign stop_burst[g] = cmd_accepted && cmd == CMD_BURST_STOP &&
                             last_burst_bank == BANK_W'(g);
      assign bank_idle[g] = (bstate[g] == BK_IDLE);
      assign bank_ok_prech[g] = may_prech(bstate[g]);
      assign bank_states[g*8 +: 8] = bstate[g];
      sbl_bank u_bank (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .go_act(go_act[g]),
        .go_read(go_read[g]),
        .go_write(go_write[g]),
        .go_prech(go_prech[g]),
        .auto_prech(auto_precharge_address_bit),
        .stop_burst(stop_burst[g]),
        .force_idle(device_state == DV_PRECH_ALL && dev_timer == '0),
        .state(bstate[g])
      );
    end
  endgenerate
endmodule : sbl_legality

// >>> tb/sbl_legality_sva.sv
/* Port checker for the bank state tracker, bound into sbl_legality.
   Assumes ce stays high while a checked sequence runs. */
`timescale 1ns/1ps
module sbl_legality_chk
  import sbl_pkg::*;
#(
  parameter int unsigned NUM_BANKS = BANKS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic clock_enable_input,
  input wire logic self_refresh_exit,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [BANK_W-1:0] bank_select,
  input wire logic auto_precharge_address_bit,
  input wire logic cmd_accepted,
  input wire logic cmd_illegal,
  input wire logic all_idle,
  input sbl_dev_t device_state,
  input wire logic [NUM_BANKS*8-1:0] bank_states
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  logic [3:0] pin;
  logic q;
  logic go;
  logic ap;
  logic [7:0] b0;
  assign pin = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
  assign q = pin[3] || pin == 4'h7;
  assign go = cmd_accepted && ce;
  assign ap = auto_precharge_address_bit;
  assign b0 = bank_states[7:0];
  quiet_cmd_a: assert property (q |-> !cmd_illegal)
    else $error("idle command flagged");
  cke_gate_a: assert property (
    !(clock_enable_input && $past(clock_enable_input)) |-> !cmd_accepted)
    else $error("command taken with clock enable low");
  act_open_a: assert property (
    go && pin == 4'h3 && bank_select == 0 |=> b0 == 8'h02 ##1 b0 == 8'h04)
    else $error("activate timing wrong");
  rd_auto_a: assert property (
    go && pin == 4'h5 && ap && bank_select == 0
    |=> b0 == 8'h20 [*4] ##1 b0 == 8'h80 ##1 b0 == 8'h01)
    else $error("auto precharge read sequence wrong");
  rd_end_a: assert property (
    go && pin == 4'h5 && !ap && bank_select == 0 ##1 q [*4]
    |-> b0 == 8'h08 ##1 b0 == 8'h04)
    else $error("read burst length wrong");
  ref_len_a: assert property (
    go && pin == 4'h1 |=> device_state == DV_REFRESH [*4]
    ##1 device_state == DV_NORMAL && all_idle)
    else $error("refresh interval wrong");
  mode_len_a: assert property (
    go && pin == 4'h0 |=> device_state == DV_MODE_LOAD [*2]
    ##1 device_state == DV_NORMAL)
    else $error("mode load interval wrong");
  pall_len_a: assert property (
    go && pin == 4'h2 && ap |=> device_state == DV_PRECH_ALL
    ##1 device_state == DV_NORMAL && all_idle)
    else $error("precharge all wrong");
  pre_idle_a: assert property (
    go && pin == 4'h2 && !ap && bank_select == 3
    && bank_states[31:24] == 8'h01 |=> bank_states[31:24] == 8'h01)
    else $error("idle bank disturbed by precharge");
endmodule : sbl_legality_chk

bind sbl_legality sbl_legality_chk #(.NUM_BANKS(NUM_BANKS)) sbl_chk_inst (
  .clk_sys, .rst, .ce, .clock_enable_input, .self_refresh_exit,
  .chip_select_n, .row_strobe_n, .column_strobe_n, .write_strobe_n,
  .bank_select, .auto_precharge_address_bit, .cmd_accepted, .cmd_illegal,
  .all_idle, .device_state, .bank_states);

// >>> tb/sbl_ctrl_model.sv
/* Controller stand-in: turns a command code into the strobe pins.
   Assumes the bench orders commands; address pins come from the bench. */
`timescale 1ns/1ps
module sbl_ctrl_model
  import sbl_pkg::*;
(
  input sbl_cmd_t cmd,
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_strobe_n
);
  logic [3:0] pins;
  assign {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = pins;
  ////////////////////////////////////////
  always_comb begin
    case (cmd)
      CMD_NOP: pins = 4'h7;
      CMD_ACTIVATE: pins = 4'h3;
      CMD_READ: pins = 4'h5;
      CMD_WRITE: pins = 4'h4;
      CMD_PRECHARGE: pins = 4'h2;
      CMD_BURST_STOP: pins = 4'h6;
      CMD_REFRESH: pins = 4'h1;
      CMD_MODE_LOAD: pins = 4'h0;
      // Deselected with strobes low: a lost select would look like mode load
      default: pins = 4'h8;
    endcase
  end
endmodule : sbl_ctrl_model

// >>> tb/test_sbl_legality.sv
/* Scenario bench for the bank state tracker.
   Assumes the checker is bound; ce drops only outside checked sequences. */
`timescale 1ns/1ps
module test_sbl_legality
  import sbl_pkg::*;
;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic clock_enable_input = 1'h1;
  logic self_refresh_exit = 1'h0;
  logic [1:0] bank_select = 2'h0;
  logic auto_precharge_address_bit = 1'h0;
  sbl_cmd_t rq = CMD_INHIBIT;
  logic chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n;
  logic cmd_accepted, cmd_illegal, all_idle;
  sbl_dev_t device_state;
  logic [31:0] bank_states;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  sbl_ctrl_model sbl_ctrl_model_inst (.cmd(rq), .chip_select_n,
    .row_strobe_n, .column_strobe_n, .write_strobe_n);
  sbl_legality #(.NUM_BANKS(4)) sbl_legality_inst (.clk_sys, .rst, .ce,
    .clock_enable_input, .self_refresh_exit, .chip_select_n, .row_strobe_n,
    .column_strobe_n, .write_strobe_n, .bank_select,
    .auto_precharge_address_bit, .cmd_accepted, .cmd_illegal, .all_idle,
    .device_state, .bank_states);
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  function automatic logic [7:0] bk(input int b);
    return bank_states[b*8+:8];
  endfunction : bk
  // Judged before the edge that takes the command; returns just after it
  task automatic go(input sbl_cmd_t c, input int b, input logic a, ok);
    rq = c;
    bank_select = b[1:0];
    auto_precharge_address_bit = a;
    @(negedge clk_sys);
    chk("accepted", ok, cmd_accepted);
    chk("illegal", !ok, cmd_illegal);
    @(posedge clk_sys);
    #1;
  endtask : go
  task automatic nop(input int n);
    rq = CMD_NOP;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : nop
  task automatic t_cke();
    clock_enable_input = 1'h0;
    go(CMD_ACTIVATE, 0, 0, 0);
    clock_enable_input = 1'h1;
    go(CMD_ACTIVATE, 0, 0, 0);
    self_refresh_exit = 1'h1;
    nop(1);
    self_refresh_exit = 1'h0;
    chk("device", 5'h10, device_state);
    go(CMD_ACTIVATE, 0, 0, 0);
    nop(3);
    chk("device", 5'h01, device_state);
  endtask : t_cke
  task automatic t_act();
    go(CMD_ACTIVATE, 0, 0, 1);
    chk("bank0", 8'h02, bk(0));
    go(CMD_ACTIVATE, 1, 0, 1);
    chk("bank0", 8'h04, bk(0));
    go(CMD_ACTIVATE, 0, 0, 0);
    go(CMD_READ, 0, 1, 1);
    chk("bank0", 8'h20, bk(0));
    go(CMD_READ, 0, 0, 0);
    nop(3);
    chk("bank0", 8'h80, bk(0));
    nop(1);
    chk("bank0", 8'h01, bk(0));
  endtask : t_act
  task automatic t_burst();
    go(CMD_ACTIVATE, 0, 0, 1);
    nop(1);
    go(CMD_WRITE, 1, 0, 1);
    chk("bank1", 8'h10, bk(1));
    go(CMD_READ, 0, 0, 1);
    chk("bank0", 8'h08, bk(0));
    go(CMD_BURST_STOP, 0, 0, 1);
    chk("bank0", 8'h04, bk(0));
    nop(4);
    chk("bank1", 8'h04, bk(1));
    go(CMD_READ, 0, 0, 1);
    nop(4);
    go(CMD_WRITE, 1, 0, 1);
    nop(3);
    chk("bank1", 8'h10, bk(1));
    nop(1);
    chk("bank1", 8'h04, bk(1));
    go(CMD_BURST_STOP, 0, 0, 0);
  endtask : t_burst
  task automatic t_pre();
    go(CMD_REFRESH, 0, 0, 0);
    go(CMD_PRECHARGE, 3, 0, 1);
    chk("bank3", 8'h01, bk(3));
    go(CMD_PRECHARGE, 0, 0, 1);
    chk("bank0", 8'h80, bk(0));
    chk("bank1", 8'h04, bk(1));
    nop(1);
    chk("bank0", 8'h01, bk(0));
    go(CMD_PRECHARGE, 2, 1, 1);
    chk("device", 5'h08, device_state);
    go(CMD_ACTIVATE, 2, 0, 0);
    chk("states", 32'h0101_0101, bank_states);
  endtask : t_pre
  task automatic t_ref();
    go(CMD_REFRESH, 0, 0, 1);
    go(CMD_MODE_LOAD, 0, 0, 0);
    nop(2);
    chk("device", 5'h02, device_state);
    nop(1);
    chk("device", 5'h01, device_state);
    go(CMD_MODE_LOAD, 0, 0, 1);
    nop(1);
    chk("device", 5'h04, device_state);
    nop(1);
    chk("idle", 1'h1, all_idle);
  endtask : t_ref
  task automatic t_wap();
    go(CMD_ACTIVATE, 2, 0, 1);
    nop(1);
    go(CMD_WRITE, 2, 1, 1);
    chk("bank2", 8'h40, bk(2));
    go(CMD_PRECHARGE, 2, 0, 0);
    // Low clock enable must freeze the auto precharge timer
    ce = 1'h0;
    nop(3);
    chk("bank2", 8'h40, bk(2));
    ce = 1'h1;
    nop(2);
    chk("bank2", 8'h40, bk(2));
    nop(1);
    chk("bank2", 8'h80, bk(2));
    nop(1);
    chk("bank2", 8'h01, bk(2));
    go(CMD_ACTIVATE, 3, 0, 1);
    rst = 1'h1;
    nop(1);
    rst = 1'h0;
    chk("states", 32'h0101_0101, bank_states);
    go(CMD_ACTIVATE, 3, 0, 0);
    go(CMD_ACTIVATE, 3, 0, 1);
  endtask : t_wap
  ////////////////////////////////////////
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Generous ceiling: the scenarios need about 75 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'h0;
    chk("states", 32'h0101_0101, bank_states);
    chk("device", 5'h01, device_state);
    nop(1);
    t_cke();
    t_act();
    t_burst();
    t_pre();
    t_ref();
    t_wap();
    close_out();
  end
endmodule : test_sbl_legality
